// File: include/regctl_pkg.sv
/*
 * Constants for the regulator control and bus-power detect block.
 * Assumes a single 50 MHz system clock and an asynchronous, active-high reset.
 */
package regctl_pkg;
	localparam int  SYNC_STAGES     = 3;
	localparam logic RESET_REG_ON   = 1'h1;
	localparam logic RESET_LOWPOWER = 1'h0;
	localparam logic RESET_POLARITY = 1'h0;
	localparam logic RESET_USB_SRC  = 1'h0;
	localparam logic MODE_NORMAL    = 1'h0;
	localparam logic MODE_SUSPEND   = 1'h1;
	localparam logic POL_LOW        = 1'h0;
	localparam logic POL_HIGH       = 1'h1;
endpackage

// File: logic/regulator_ctrl_vbus_detect.sv
/*
 * Regulator enable and mode control, bus-power level detection with a
 * level-sensitive interrupt and an optional system reset request.
 * Assumes the bus-power pin is asynchronous to MCLK and that the analog
 * regulator takes its enable and mode from the ports below.
 */
`timescale 1ns/10ps

module regulator_ctrl_vbus_detect
	import regctl_pkg::*;
(
	input  wire logic MCLK,
	input  wire logic RESET,
	input  wire logic VBUS_PIN,
	input  wire logic REG_ON_WR,
	input  wire logic REG_ON_IN,
	input  wire logic LOW_POWER_WR,
	input  wire logic LOW_POWER_IN,
	input  wire logic POLARITY_WR,
	input  wire logic POLARITY_IN,
	input  wire logic IRQ_ENABLE,
	input  wire logic USB_RESET_SOURCE,
	output logic      REGULATOR_ON,
	output logic      LOW_POWER_SELECT,
	output logic      BUS_POWER_POLARITY_SELECT,
	output logic      BUS_POWER_LEVEL_STATUS,
	output logic      BUS_POWER_IRQ,
	output logic      USB_SYSTEM_RESET
);
	logic [SYNC_STAGES-1:0] sync;
	logic [SYNC_STAGES-1:0] next_sync;
	logic                   level;
	logic                   next_level;
	logic                   reg_on;
	logic                   next_reg_on;
	logic                   low_power;
	logic                   next_low_power;
	logic                   polarity;
	logic                   next_polarity;
	logic                   match;

	// three stages; level only moves once the last two agree, which
	// rejects a single-cycle glitch at the price of one extra cycle
	always_comb begin
		next_sync  = {sync[SYNC_STAGES-2:0], VBUS_PIN};
		next_level = level;
		if (sync[SYNC_STAGES-1] == sync[SYNC_STAGES-2]) begin
			next_level = sync[SYNC_STAGES-1];
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			sync  <= '0;
			level <= 1'h0;
		end else begin
			sync  <= next_sync;
			level <= next_level;
		end
	end

	// a strobe that is held just rewrites the same value, so a slow
	// writer is harmless; a value without its strobe is ignored
	always_comb begin
		next_reg_on    = reg_on;
		next_low_power = low_power;
		next_polarity  = polarity;
		if (REG_ON_WR) begin
			next_reg_on = REG_ON_IN;
		end
		if (LOW_POWER_WR) begin
			next_low_power = LOW_POWER_IN;
		end
		if (POLARITY_WR) begin
			next_polarity = POLARITY_IN;
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			reg_on    <= RESET_REG_ON;
			low_power <= RESET_LOWPOWER;
			polarity  <= RESET_POLARITY;
		end else begin
			reg_on    <= next_reg_on;
			low_power <= next_low_power;
			polarity  <= next_polarity;
		end
	end

	// polarity high compares against a high level, low against low
	function automatic logic polarity_match(input logic lvl,
		input logic pol);
		polarity_match = (pol == POL_HIGH) ? lvl : ~lvl;
	endfunction

	assign match = polarity_match(level, polarity);

	assign REGULATOR_ON              = reg_on;
	assign LOW_POWER_SELECT          = low_power;
	assign BUS_POWER_POLARITY_SELECT = polarity;
	assign BUS_POWER_LEVEL_STATUS    = level;
	// no pending flag is kept: the request is the live match itself
	assign BUS_POWER_IRQ             = IRQ_ENABLE & match;
	assign USB_SYSTEM_RESET          = USB_RESET_SOURCE & match;

	AST_IRQ_LEVEL: assert property (@(posedge MCLK) disable iff (RESET)
		BUS_POWER_IRQ == (IRQ_ENABLE && (level == polarity)))
		else $error("interrupt does not follow live match");

	AST_IRQ_DROP: assert property (@(posedge MCLK) disable iff (RESET)
		(IRQ_ENABLE && !POLARITY_WR && $rose(level) && polarity == POL_LOW)
		|-> !BUS_POWER_IRQ)
		else $error("low polarity interrupt held after level rose");

	AST_RESET_MATCH: assert property (@(posedge MCLK) disable iff (RESET)
		USB_SYSTEM_RESET == (USB_RESET_SOURCE && (level == polarity)))
		else $error("system reset request wrong");

	AST_STATUS_SYNC: assert property (@(posedge MCLK) disable iff (RESET)
		(VBUS_PIN [*4]) |=> BUS_POWER_LEVEL_STATUS)
		else $error("status did not follow steady high pin");

	AST_STATUS_LOW: assert property (@(posedge MCLK) disable iff (RESET)
		(!VBUS_PIN [*4]) |=> !BUS_POWER_LEVEL_STATUS)
		else $error("status did not follow steady low pin");

	AST_GLITCH: assert property (@(posedge MCLK) disable iff (RESET)
		$changed(BUS_POWER_LEVEL_STATUS) |-> $past(sync[SYNC_STAGES-1])
		== $past(sync[SYNC_STAGES-2]))
		else $error("status changed without agreeing stages");

	AST_REG_ON: assert property (@(posedge MCLK) disable iff (RESET)
		REG_ON_WR |=> REGULATOR_ON == $past(REG_ON_IN))
		else $error("regulator enable write lost");

	AST_MODE: assert property (@(posedge MCLK) disable iff (RESET)
		!LOW_POWER_WR |=> $stable(LOW_POWER_SELECT))
		else $error("mode changed without write");

	AST_POL: assert property (@(posedge MCLK) disable iff (RESET)
		POLARITY_WR |=> BUS_POWER_POLARITY_SELECT == $past(POLARITY_IN))
		else $error("polarity write lost");

	AST_IRQ_OFF: assert property (@(posedge MCLK)
		disable iff (RESET) !IRQ_ENABLE |-> !BUS_POWER_IRQ)
		else $error("interrupt raised while disabled");

	AST_IRQ_RISE: assert property (@(posedge MCLK)
		disable iff (RESET)
		(IRQ_ENABLE && $rose(level) && polarity == POL_HIGH) |-> BUS_POWER_IRQ)
		else $error("high polarity interrupt missing after level rose");

	AST_IRQ_FALL: assert property (@(posedge MCLK)
		disable iff (RESET)
		(IRQ_ENABLE && $fell(level) && polarity == POL_HIGH) |-> !BUS_POWER_IRQ)
		else $error("high polarity interrupt held after level fell");

	AST_RESET_OFF: assert property (@(posedge MCLK)
		disable iff (RESET) !USB_RESET_SOURCE |-> !USB_SYSTEM_RESET)
		else $error("system reset requested while source not selected");

	AST_RESET_RISE: assert property (@(posedge MCLK)
		disable iff (RESET) (USB_RESET_SOURCE && $rose(level)
		&& polarity == POL_HIGH) |-> USB_SYSTEM_RESET)
		else $error("system reset missing after level rose");

	AST_RESET_FALL: assert property (@(posedge MCLK)
		disable iff (RESET) (USB_RESET_SOURCE && $fell(level)
		&& polarity == POL_HIGH) |-> !USB_SYSTEM_RESET)
		else $error("system reset held after level fell");

	AST_RESET_POL: assert property (@(posedge MCLK)
		disable iff (RESET) (USB_RESET_SOURCE && $rose(level)
		&& polarity == POL_LOW) |-> !USB_SYSTEM_RESET)
		else $error("low polarity reset held after level rose");

	AST_STATUS_RISE: assert property (@(posedge MCLK)
		disable iff (RESET) $rose(BUS_POWER_LEVEL_STATUS)
		|-> ($past(VBUS_PIN, 3) && $past(VBUS_PIN, 4)))
		else $error("status rose before pin was high twice");

	AST_STATUS_FALL: assert property (@(posedge MCLK)
		disable iff (RESET) $fell(BUS_POWER_LEVEL_STATUS)
		|-> (!$past(VBUS_PIN, 3) && !$past(VBUS_PIN, 4)))
		else $error("status fell before pin was low twice");

	AST_STATUS_HOLD: assert property (@(posedge MCLK)
		disable iff (RESET) (sync[SYNC_STAGES-1] != sync[SYNC_STAGES-2])
		|=> $stable(BUS_POWER_LEVEL_STATUS))
		else $error("status moved while stages disagree");

	AST_REG_HOLD: assert property (@(posedge MCLK)
		disable iff (RESET) !REG_ON_WR |=> $stable(REGULATOR_ON))
		else $error("regulator enable changed without write");

	AST_MODE_WRITE: assert property (@(posedge MCLK)
		disable iff (RESET) LOW_POWER_WR |=> LOW_POWER_SELECT == $past(LOW_POWER_IN))
		else $error("mode write lost");

	AST_POL_HOLD: assert property (@(posedge MCLK)
		disable iff (RESET) !POLARITY_WR |=> $stable(BUS_POWER_POLARITY_SELECT))
		else $error("polarity changed without write");

	// reset values are checked from the second reset edge on: before the
	// first edge the registers have not yet been cleared
	AST_RESET_STATE: assert property (@(posedge MCLK)
		RESET [*2] |-> (REGULATOR_ON == RESET_REG_ON
		&& LOW_POWER_SELECT == RESET_LOWPOWER
		&& BUS_POWER_POLARITY_SELECT == RESET_POLARITY
		&& !BUS_POWER_LEVEL_STATUS))
		else $error("outputs not at reset values during reset");

	AST_RESET_IRQ: assert property (@(posedge MCLK)
		RESET [*2] |-> (BUS_POWER_IRQ == IRQ_ENABLE
		&& USB_SYSTEM_RESET == USB_RESET_SOURCE))
		else $error("requests wrong during reset");
endmodule

// File: tb/regulator_ctrl_vbus_detect_tb_top.sv
/* self-checking bench for the regulator control and bus-power detect.
 * assumes the design package is compiled first. */
`timescale 1ns/10ps
module regulator_ctrl_vbus_detect_tb_top
	import regctl_pkg::*;
;
	logic mclk = 0, reset = 1, lvl = 0, vb, rw = 0, rv = 0;
	logic lw = 0, lv = 0, pw = 0, pv = 0, ien = 0, usb = 0;
	logic ron, lps, pol, st, irq, srst;
	int   miscompares = 0, checks = 0;
	initial forever #10 mclk = ~mclk;
	vbus_source i_src (.LEVEL(lvl), .PIN(vb));
	regulator_ctrl_vbus_detect i_dut (.MCLK(mclk), .RESET(reset),
		.VBUS_PIN(vb), .REG_ON_WR(rw), .REG_ON_IN(rv),
		.LOW_POWER_WR(lw), .LOW_POWER_IN(lv), .POLARITY_WR(pw),
		.POLARITY_IN(pv), .IRQ_ENABLE(ien), .USB_RESET_SOURCE(usb),
		.REGULATOR_ON(ron), .LOW_POWER_SELECT(lps),
		.BUS_POWER_POLARITY_SELECT(pol), .BUS_POWER_LEVEL_STATUS(st),
		.BUS_POWER_IRQ(irq), .USB_SYSTEM_RESET(srst));
	task automatic cmp(input string n, input logic e, input logic s);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s exp %b got %b", n, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic t_regs;
		cmp("ron", RESET_REG_ON, ron);
		cmp("lps", RESET_LOWPOWER, lps);
		cmp("pol", RESET_POLARITY, pol);
		cmp("st", 1'h0, st);
		{rw, rv, lw, lv, pw, pv} = 6'h2F;
		tick(1);
		cmp("ron", 1'h0, ron);
		cmp("lps", MODE_SUSPEND, lps);
		cmp("pol", POL_HIGH, pol);
		// values without their strobes must be ignored
		{rw, rv, lw, lv, pw, pv} = 6'h10;
		tick(1);
		cmp("ron", 1'h0, ron);
		cmp("lps", MODE_SUSPEND, lps);
		cmp("pol", POL_HIGH, pol);
		{rw, rv, lw, lv, pw, pv} = 6'h39;
		tick(1);
		cmp("ron", 1'h1, ron);
		cmp("lps", MODE_NORMAL, lps);
		cmp("pol", POL_HIGH, pol);
		{rw, lw} = 2'h0;
	endtask
	task automatic t_level;
		{ien, usb, lvl} = 3'h7;
		tick(3);
		cmp("st", 1'h0, st);
		tick(1);
		cmp("st", 1'h1, st);
		cmp("irq", 1'h1, irq);
		cmp("srst", 1'h1, srst);
		lvl = 0;
		tick(4);
		cmp("st", 1'h0, st);
		cmp("irq", 1'h0, irq);
		cmp("srst", 1'h0, srst);
		{pw, pv} = 2'h2;
		tick(1);
		pw = 0;
		cmp("irq", 1'h1, irq);
		cmp("srst", 1'h1, srst);
		{ien, usb} = 2'h0;
		tick(1);
		cmp("irq", 1'h0, irq);
		cmp("srst", 1'h0, srst);
		// a one-cycle pulse must never reach the status
		lvl = 1;
		tick(1);
		lvl = 0;
		repeat (4) begin
			tick(1);
			cmp("st", 1'h0, st);
		end
		{ien, usb, lvl} = 3'h7;
		tick(4);
		cmp("st", 1'h1, st);
		cmp("irq", 1'h0, irq);
		cmp("srst", 1'h0, srst);
	endtask
	task automatic t_reset;
		{rw, rv, lw, lv, pw, pv} = 6'h2F;
		tick(1);
		cmp("pol", POL_HIGH, pol);
		{rw, lw, pw, reset} = 4'h1;
		tick(2);
		cmp("ron", RESET_REG_ON, ron);
		cmp("lps", RESET_LOWPOWER, lps);
		cmp("pol", RESET_POLARITY, pol);
		cmp("st", 1'h0, st);
		cmp("irq", 1'h1, irq);
		cmp("srst", 1'h1, srst);
		// the first edge after release already takes a write
		{reset, rw, rv} = 3'h2;
		tick(1);
		cmp("ron", 1'h0, ron);
		rw = 0;
		tick(3);
		cmp("st", 1'h1, st);
		cmp("irq", 1'h0, irq);
		cmp("srst", 1'h0, srst);
	endtask
	initial begin
		tick(3);
		reset = 0;
		t_regs();
		t_level();
		t_reset();
		give_verdict();
	end
	initial begin
		#20000;
		miscompares++;
		give_verdict();
	end
endmodule

// File: tb/vbus_source.sv
/* bus-power supply model for the far side of the pin.
 * assumes the bench sets the supply level off the clock edge. */
`timescale 1ns/10ps
module vbus_source (
	input  wire logic LEVEL,
	output logic      PIN
);
	// a host supply has no clock, so the pin changes at any time
	assign PIN = LEVEL;
endmodule
